// ===== logic/qpin_pkg.sv
// Constants for the quadrature phase and test reset pin multiplexer.
package qpin_pkg;
    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] OFF_PORTC_PUR  = 8'h00;
    localparam logic [7:0] OFF_SYS_PUDR   = 8'h04;
    localparam logic [7:0] OFF_PERIPH_EN  = 8'h08;
    localparam logic [7:0] OFF_TIMER_SEL  = 8'h0C;
    localparam logic [7:0] OFF_DIR        = 8'h10;
    localparam logic [7:0] OFF_DATA_OUT   = 8'h14;
    localparam logic [7:0] OFF_STATUS     = 8'h18;
    // Field positions.
    localparam int BIT_PHASE_A   = 4;
    localparam int BIT_PHASE_B   = 5;
    localparam int BIT_SCAN_PUD  = 0;
    localparam int BIT_TAP_RESET = 0;
    localparam int BIT_TRST_PIN  = 1;
    // Reset values.
    localparam logic [7:0] RST_PORTC_PUR = 8'h30;
    localparam logic [7:0] RST_SYS_PUDR  = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN = 8'h30;
    localparam logic [7:0] RST_TIMER_SEL = 8'h00;
    localparam logic [7:0] RST_DIR       = 8'h00;
    localparam logic [7:0] RST_DATA_OUT  = 8'h00;
    // Synchroniser depth ahead of the settled value.
    localparam int SYNC_STAGES = 3;
endpackage : qpin_pkg

// ===== logic/qpin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module qpin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    output var  logic value
);
    logic s1;
    logic s2;
    logic s3;

    // Stage one feeds stage two only; the settled value moves when two and three agree.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1    <= RESET_VAL;
            s2    <= RESET_VAL;
            s3    <= RESET_VAL;
            value <= RESET_VAL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                value <= s3;
            end
        end
    end
endmodule // qpin_sync
`default_nettype wire

// ===== logic/qpin_top.sv
// Pin multiplexer and pull-up control for the quadrature phase pins and the test reset pin.
// Operation
// - The test access port controller is held in reset while the active-low test reset pin is low.
// - The test reset pin pull-up is on by default and is removed by setting the scan pull-up bit.
// - Phase A pin carries quadrature phase A, timer A channel 0 or port C line 4, quadrature at reset.
// - Phase A pull-up is on at reset and off when bit 4 of the port C pull-up register is clear.
// - Phase B pin carries quadrature phase B, timer A channel 1 or port C line 5, quadrature at reset.
// - Phase B pull-up is on at reset and off when bit 5 of the port C pull-up register is clear.
// - With the general-purpose function selected, each phase pin is an input or output on its own.
`timescale 1ns/1ps
`default_nettype none
module qpin_top (
    input  wire logic        clk,
    input  wire logic        reset,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    // Phase A pad.
    input  wire logic        phase_a_pin_in,
    output var  logic        phase_a_pin_out,
    output var  logic        phase_a_pin_oe,
    output var  logic        phase_a_pullup_en,
    // Phase B pad.
    input  wire logic        phase_b_pin_in,
    output var  logic        phase_b_pin_out,
    output var  logic        phase_b_pin_oe,
    output var  logic        phase_b_pullup_en,
    // Test reset pad.
    input  wire logic        test_reset_n_pin,
    output var  logic        test_reset_pullup_en,
    output var  logic        tap_reset,
    // Core side.
    output var  logic        quad_phase_a_in,
    output var  logic        quad_phase_b_in,
    input  wire logic        timer_a_ch0_out,
    input  wire logic        timer_a_ch0_oe,
    output var  logic        timer_a_ch0,
    input  wire logic        timer_a_ch1_out,
    input  wire logic        timer_a_ch1_oe,
    output var  logic        timer_a_ch1
);
    localparam int A = qpin_pkg::BIT_PHASE_A;
    localparam int B = qpin_pkg::BIT_PHASE_B;

    logic [7:0] port_c_pullup_enable_reg;
    logic [7:0] system_pullup_disable_reg;
    logic [7:0] periph_en_reg;
    logic [7:0] timer_sel_reg;
    logic [7:0] dir_reg;
    logic [7:0] data_out_reg;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       a_val;
    logic       b_val;
    logic       trst_val;

    // Pad drive for one pin: quadrature input, timer channel or general-purpose line.
    function automatic logic [1:0] pad_drive(input logic periph, input logic tsel,
                                             input logic t_out, input logic t_oe,
                                             input logic dir, input logic dout);
        logic [1:0] r;
        r = 2'h0;
        if (periph && tsel) begin
            r = {t_oe, t_out};
        end else if (!periph) begin
            r = {dir, dout};
        end
        return r;
    endfunction

    // Pins arrive from outside the clock domain; test reset settles low as if held at reset.
    qpin_sync #(.RESET_VAL(1'b1)) u_sync_a (
        .clk   (clk),
        .reset (reset),
        .pin   (phase_a_pin_in),
        .value (a_val)
    );
    qpin_sync #(.RESET_VAL(1'b1)) u_sync_b (
        .clk   (clk),
        .reset (reset),
        .pin   (phase_b_pin_in),
        .value (b_val)
    );
    qpin_sync #(.RESET_VAL(1'b0)) u_sync_trst (
        .clk   (clk),
        .reset (reset),
        .pin   (test_reset_n_pin),
        .value (trst_val)
    );

    // Bus decode: a write is taken in the address phase and completed in the data phase.
    wire        addr_phase = hsel && htrans[1] && hready;
    wire [7:0]  rd_addr    = haddr[7:0];
    wire        wr_hit     = wr_pend;
    wire        wr_pur     = wr_hit && wr_addr == qpin_pkg::OFF_PORTC_PUR;
    wire        wr_pudr    = wr_hit && wr_addr == qpin_pkg::OFF_SYS_PUDR;
    wire        wr_pe      = wr_hit && wr_addr == qpin_pkg::OFF_PERIPH_EN;
    wire        wr_tsel    = wr_hit && wr_addr == qpin_pkg::OFF_TIMER_SEL;
    wire        wr_dir     = wr_hit && wr_addr == qpin_pkg::OFF_DIR;
    wire        wr_dout    = wr_hit && wr_addr == qpin_pkg::OFF_DATA_OUT;
    wire [7:0]  pin_mask   = 8'h30;
    wire [7:0]  status     = {2'h0, b_val, a_val, 2'h0, trst_val, tap_reset};
    wire [7:0]  next_rdata = (rd_addr == qpin_pkg::OFF_PORTC_PUR) ? port_c_pullup_enable_reg :
                             (rd_addr == qpin_pkg::OFF_SYS_PUDR)  ? system_pullup_disable_reg :
                             (rd_addr == qpin_pkg::OFF_PERIPH_EN) ? periph_en_reg :
                             (rd_addr == qpin_pkg::OFF_TIMER_SEL) ? timer_sel_reg :
                             (rd_addr == qpin_pkg::OFF_DIR)       ? dir_reg :
                             (rd_addr == qpin_pkg::OFF_DATA_OUT)  ? data_out_reg :
                             (rd_addr == qpin_pkg::OFF_STATUS)    ? status : 8'h00;

    // Every access finishes with no wait state and an OKAY response.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= addr_phase && hwrite;
            wr_addr   <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                hrdata <= {24'h0, next_rdata};
            end
        end
    end

    // Control registers; only the pin bits and the scan pull-up bit (bit 0 of the system register) are writable, the rest read as zero.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_c_pullup_enable_reg  <= qpin_pkg::RST_PORTC_PUR;
            system_pullup_disable_reg <= qpin_pkg::RST_SYS_PUDR;
            periph_en_reg             <= qpin_pkg::RST_PERIPH_EN;
            timer_sel_reg             <= qpin_pkg::RST_TIMER_SEL;
            dir_reg                   <= qpin_pkg::RST_DIR;
            data_out_reg              <= qpin_pkg::RST_DATA_OUT;
        end else begin
            if (wr_pur) port_c_pullup_enable_reg <= hwdata[7:0] & pin_mask;
            if (wr_pudr) system_pullup_disable_reg <= hwdata[7:0] & 8'h01;
            if (wr_pe) periph_en_reg <= hwdata[7:0] & pin_mask;
            if (wr_tsel) timer_sel_reg <= hwdata[7:0] & pin_mask;
            if (wr_dir) dir_reg <= hwdata[7:0] & pin_mask;
            if (wr_dout) data_out_reg <= hwdata[7:0] & pin_mask;
        end
    end

    // Pad drive selection, one decision per pin.
    wire [1:0] next_a_drive = pad_drive(periph_en_reg[A], timer_sel_reg[A], timer_a_ch0_out,
                                        timer_a_ch0_oe, dir_reg[A], data_out_reg[A]);
    wire [1:0] next_b_drive = pad_drive(periph_en_reg[B], timer_sel_reg[B], timer_a_ch1_out,
                                        timer_a_ch1_oe, dir_reg[B], data_out_reg[B]);
    wire       quad_a_sel   = periph_en_reg[A] && !timer_sel_reg[A];
    wire       quad_b_sel   = periph_en_reg[B] && !timer_sel_reg[B];

    // Pad and core outputs are registered; unselected functions see a quiet zero.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_a_pin_out      <= 1'b0;
            phase_a_pin_oe       <= 1'b0;
            phase_b_pin_out      <= 1'b0;
            phase_b_pin_oe       <= 1'b0;
            phase_a_pullup_en    <= 1'b1;
            phase_b_pullup_en    <= 1'b1;
            test_reset_pullup_en <= 1'b1;
            tap_reset            <= 1'b1;
            quad_phase_a_in      <= 1'b0;
            quad_phase_b_in      <= 1'b0;
            timer_a_ch0          <= 1'b0;
            timer_a_ch1          <= 1'b0;
        end else begin
            {phase_a_pin_oe, phase_a_pin_out} <= next_a_drive;
            {phase_b_pin_oe, phase_b_pin_out} <= next_b_drive;
            phase_a_pullup_en    <= port_c_pullup_enable_reg[A];
            phase_b_pullup_en    <= port_c_pullup_enable_reg[B];
            test_reset_pullup_en <= !system_pullup_disable_reg[qpin_pkg::BIT_SCAN_PUD];
            tap_reset            <= !trst_val;
            quad_phase_a_in      <= quad_a_sel && a_val;
            quad_phase_b_in      <= quad_b_sel && b_val;
            timer_a_ch0          <= periph_en_reg[A] && timer_sel_reg[A] && a_val;
            timer_a_ch1          <= periph_en_reg[B] && timer_sel_reg[B] && b_val;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_tap_reset_low: assert property (!test_reset_n_pin [*6] |=> tap_reset)
        else $error("Test reset held low but tap reset not asserted.");
    chk_tap_reset_release: assert property (test_reset_n_pin [*6] |=> !tap_reset)
        else $error("Test reset held high but tap reset still asserted.");
    chk_scan_pullup_off: assert property (wr_pudr && hwdata[0] |=> ##1 !test_reset_pullup_en)
        else $error("Scan pull-up disable bit did not remove the pull-up.");
    chk_phase_a_quad: assert property (quad_a_sel |=> !phase_a_pin_oe)
        else $error("Phase A pad driven while quadrature function selected.");
    chk_phase_a_pullup: assert property (wr_pur && !hwdata[4] |=> ##1 !phase_a_pullup_en)
        else $error("Phase A pull-up stayed on after its bit was cleared.");
    chk_phase_b_quad: assert property (quad_b_sel && $stable(b_val)
                                       |=> quad_phase_b_in == $past(b_val))
        else $error("Phase B level not passed to quadrature input.");
    chk_phase_b_pullup: assert property (wr_pur && hwdata[5] |=> ##1 phase_b_pullup_en)
        else $error("Phase B pull-up not enabled after its bit was set.");
    chk_gpio_dir: assert property (!periph_en_reg[A] |=> phase_a_pin_oe == $past(dir_reg[A]))
        else $error("Phase A pad enable does not follow its direction bit.");
    chk_timer_drive: assert property (periph_en_reg[B] && timer_sel_reg[B]
                                      |=> phase_b_pin_oe == $past(timer_a_ch1_oe))
        else $error("Phase B pad enable does not follow the timer channel.");
endmodule // qpin_top
`default_nettype wire

// ===== bench/qpin_probe.sv
// Behavioural encoder and debug probe that sets the three pad levels.
`timescale 1ns/1ps
`default_nettype none
module qpin_probe (
    input  wire logic clk,
    input  wire logic enc_on,
    input  wire logic enc_a,
    input  wire logic enc_b,
    input  wire logic trst_low,
    input  wire logic a_oe,
    input  wire logic a_out,
    input  wire logic a_pu,
    input  wire logic b_oe,
    input  wire logic b_out,
    input  wire logic b_pu,
    input  wire logic t_pu,
    output wire logic a_pad,
    output wire logic b_pad,
    output wire logic t_pad
);
    logic flip = 1'b0;
    // A pad with no driver and no pull-up wanders, so it toggles each cycle.
    always @(posedge clk) begin
        flip <= ~flip;
    end
    // Device drive wins, then the encoder, then the pull-up.
    assign a_pad = a_oe ? a_out : (enc_on ? enc_a : (a_pu ? 1'b1 : flip));
    assign b_pad = b_oe ? b_out : (enc_on ? enc_b : (b_pu ? 1'b1 : flip));
    // Test reset goes low with device reset, or stays high for a debug-only reset.
    assign t_pad = trst_low ? 1'b0 : (t_pu ? 1'b1 : flip);
endmodule // qpin_probe
`default_nettype wire

// ===== bench/quad_phase_and_test_reset_pins_bench.sv
// Self-checking bench for the phase and test reset pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
module quad_phase_and_test_reset_pins_bench;
    logic clk, reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic a_pad, a_out, a_oe, a_pu, b_pad, b_out, b_oe, b_pu, t_pad, t_pu, tap;
    logic qa, qb, t0o, t0e, t0, t1o, t1e, t1, enc_on, enc_a, enc_b, trst_low;
    int fail_count = 0;
    int check_count = 0;
    qpin_top i_qpin_top (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_a_pin_in(a_pad),
        .phase_a_pin_out(a_out), .phase_a_pin_oe(a_oe), .phase_a_pullup_en(a_pu),
        .phase_b_pin_in(b_pad), .phase_b_pin_out(b_out), .phase_b_pin_oe(b_oe),
        .phase_b_pullup_en(b_pu), .test_reset_n_pin(t_pad), .test_reset_pullup_en(t_pu),
        .tap_reset(tap), .quad_phase_a_in(qa), .quad_phase_b_in(qb), .timer_a_ch0_out(t0o),
        .timer_a_ch0_oe(t0e), .timer_a_ch0(t0), .timer_a_ch1_out(t1o), .timer_a_ch1_oe(t1e),
        .timer_a_ch1(t1));
    qpin_probe i_qpin_probe (.clk(clk), .enc_on(enc_on), .enc_a(enc_a), .enc_b(enc_b),
        .trst_low(trst_low), .a_oe(a_oe), .a_out(a_out), .a_pu(a_pu), .b_oe(b_oe),
        .b_out(b_out), .b_pu(b_pu), .t_pu(t_pu), .a_pad(a_pad), .b_pad(b_pad), .t_pad(t_pad));
    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Lets n edges pass, then steps clear of the edge so outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One single AHB-Lite transfer; waits on hready rather than assuming latency.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'b10; hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
        cyc(3);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h00000000, rd);
        chk("read", rd, exp);
        chk("hresp", hresp, 1'b0);
    endtask
    task automatic t_defaults;
        rreg(qpin_pkg::OFF_PORTC_PUR, 32'h00000030);
        rreg(qpin_pkg::OFF_SYS_PUDR, 32'h00000000);
        rreg(qpin_pkg::OFF_PERIPH_EN, 32'h00000030);
        rreg(qpin_pkg::OFF_TIMER_SEL, 32'h00000000);
        rreg(qpin_pkg::OFF_DIR, 32'h00000000);
        rreg(8'h1C, 32'h00000000);
        chk("tap idle", tap, 1'b0);
    endtask
    // Every encoder phase pair must reach the decoder while quadrature is selected.
    task automatic t_quad;
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            enc_a <= v[0]; enc_b <= v[1];
            cyc(8);
            chk("quad a", qa, v[0]);
            chk("quad b", qb, v[1]);
            chk("timer0 idle", t0, 1'b0);
            chk("pad a undriven", a_oe, 1'b0);
        end
    endtask
    task automatic t_pullups;
        wreg(qpin_pkg::OFF_PORTC_PUR, 32'h00000010);
        chk("pull a", a_pu, 1'b1);
        chk("pull b", b_pu, 1'b0);
        wreg(qpin_pkg::OFF_PORTC_PUR, 32'h00000000);
        chk("pull a off", a_pu, 1'b0);
        wreg(qpin_pkg::OFF_PORTC_PUR, 32'hFFFFFFFF);
        rreg(qpin_pkg::OFF_PORTC_PUR, 32'h00000030);
        wreg(qpin_pkg::OFF_SYS_PUDR, 32'h00000001);
        chk("pull trst off", t_pu, 1'b0);
        wreg(qpin_pkg::OFF_SYS_PUDR, 32'h00000000);
        chk("pull trst on", t_pu, 1'b1);
    endtask
    task automatic t_gpio;
        @(posedge clk);
        enc_b <= 1'b1;
        wreg(qpin_pkg::OFF_PERIPH_EN, 32'h00000000);
        wreg(qpin_pkg::OFF_DIR, 32'h00000010);
        wreg(qpin_pkg::OFF_DATA_OUT, 32'h00000030);
        cyc(8);
        chk("gpio a oe", a_oe, 1'b1);
        chk("gpio a out", a_out, 1'b1);
        chk("gpio b oe", b_oe, 1'b0);
        chk("quad a off", qa, 1'b0);
        rreg(qpin_pkg::OFF_STATUS, 32'h00000032);
        wreg(qpin_pkg::OFF_DIR, 32'h00000020);
        chk("gpio a in", a_oe, 1'b0);
        chk("gpio b out", b_oe, 1'b1);
        chk("gpio b level", b_out, 1'b1);
        wreg(qpin_pkg::OFF_DIR, 32'h00000000);
        wreg(qpin_pkg::OFF_PERIPH_EN, 32'h00000030);
    endtask
    task automatic t_timer;
        @(posedge clk);
        t0e <= 1'b1; t0o <= 1'b1;
        wreg(qpin_pkg::OFF_TIMER_SEL, 32'h00000030);
        cyc(8);
        chk("timer a oe", a_oe, 1'b1);
        chk("timer a out", a_out, 1'b1);
        chk("timer0 echo", t0, 1'b1);
        chk("timer b oe", b_oe, 1'b0);
        chk("timer1 in", t1, 1'b1);
        chk("quad b off", qb, 1'b0);
        @(posedge clk);
        t0o <= 1'b0;
        cyc(3);
        chk("timer a low", a_out, 1'b0);
        wreg(qpin_pkg::OFF_TIMER_SEL, 32'h00000000);
        @(posedge clk);
        t0e <= 1'b0;
    endtask
    task automatic t_tap;
        @(posedge clk);
        trst_low <= 1'b1;
        cyc(6);
        chk("tap held", tap, 1'b1);
        @(posedge clk);
        trst_low <= 1'b0;
        cyc(8);
        chk("tap freed", tap, 1'b0);
    endtask
    // A device reset in mid-run with test reset left high, as a debugger would apply it.
    // Registers must return to their defaults, and the tap must come free again on its own.
    task automatic t_debug_reset;
        wreg(qpin_pkg::OFF_PORTC_PUR, 32'h00000000);
        wreg(qpin_pkg::OFF_PERIPH_EN, 32'h00000000);
        @(posedge clk);
        reset <= 1'b1;
        cyc(1);
        chk("reset pulls again", {a_pu, b_pu, t_pu, a_oe, b_oe}, 5'h1C);
        @(posedge clk);
        reset <= 1'b0;
        cyc(8);
        chk("tap free after reset", tap, 1'b0);
        rreg(qpin_pkg::OFF_PORTC_PUR, 32'h00000030);
        rreg(qpin_pkg::OFF_PERIPH_EN, 32'h00000030);
    endtask
    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    // Test reset is held low alongside device reset.
    initial begin
        reset = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; t0o = 1'b0; t0e = 1'b0; t1o = 1'b0; t1e = 1'b0;
        enc_on = 1'b1; enc_a = 1'b0; enc_b = 1'b0; trst_low = 1'b1;
        cyc(1);
        chk("reset pulls", {a_pu, b_pu, t_pu, a_oe, b_oe, tap}, 6'h39);
        @(posedge clk);
        reset <= 1'b0; trst_low <= 1'b0;
        cyc(8);
        t_defaults();
        t_quad();
        t_pullups();
        t_gpio();
        t_timer();
        t_tap();
        t_debug_reset();
        wrap_up();
    end
endmodule // quad_phase_and_test_reset_pins_bench
`default_nettype wire
